// [shared/dcrs_pkg.sv]
// Notes on behaviour
// RL1: Power-up sets divisor high to 0x00, low to 0x01; reset pin leaves both alone.
// RL2: Reset clears control registers, interrupt source 0x01, line status 0x60, scratch 0xff.
// RL3: Reset clears modem deltas; upper modem status shows inverted pin levels at once.
// RL4: In reset transmit, outputs two, rts, dtr, rx-ready high; tx-ready low; alert per mode.
// RL5: Sleep isolation cuts bus, strobes, select and serial receive; modem inputs stay watched.
package dcrs_pkg;

  // Register byte addresses, one aligned word each
  localparam logic [7:0] ADDR_DIV_LOW   = 8'h00;
  localparam logic [7:0] ADDR_DIV_HIGH  = 8'h04;
  localparam logic [7:0] ADDR_FRAC_DIV  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0c;
  localparam logic [7:0] ADDR_FIFO_CTL  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_SRC   = 8'h14;
  localparam logic [7:0] ADDR_LINE_FMT  = 8'h18;
  localparam logic [7:0] ADDR_MODEM_OUT = 8'h1c;
  localparam logic [7:0] ADDR_LINE_STAT = 8'h20;
  localparam logic [7:0] ADDR_MODEM_IN  = 8'h24;
  localparam logic [7:0] ADDR_SCRATCH   = 8'h28;
  localparam logic [7:0] ADDR_ENH_FEAT  = 8'h2c;
  localparam logic [7:0] ADDR_RESUME1   = 8'h30;
  localparam logic [7:0] ADDR_RESUME2   = 8'h34;
  localparam logic [7:0] ADDR_PAUSE1    = 8'h38;
  localparam logic [7:0] ADDR_PAUSE2    = 8'h3c;
  localparam logic [7:0] ADDR_HOLDING   = 8'h40;
  localparam logic [7:0] ADDR_CHAN_STAT = 8'h44;

  // Values after power-up; all but the divisor ones also after reset
  localparam logic [7:0] RST_DIV_LOW   = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH  = 8'h00;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_IRQ_SRC   = 8'h01;
  localparam logic [7:0] RST_LINE_STAT = 8'h60;
  localparam logic [7:0] RST_SCRATCH   = 8'hff;

  // Interrupt source codes, highest priority first
  localparam logic [7:0] SRC_RX_DATA   = 8'h04;
  localparam logic [7:0] SRC_TX_EMPTY  = 8'h02;
  localparam logic [7:0] SRC_MODEM     = 8'h00;

  // Field positions
  localparam int unsigned BIT_ENH_ENABLE = 4;
  localparam int unsigned BIT_SLEEP_EN   = 4;
  localparam int unsigned BIT_LOOPBACK   = 4;
  localparam int unsigned BIT_BREAK      = 6;
  localparam int unsigned BIT_RX_RESET   = 1;
  localparam int unsigned BIT_TX_RESET   = 2;

  // Bus request carried through the isolation stage
  typedef struct packed {
    logic       sel;
    logic       enable;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dcrs_bus_req_type;

  // Active-low modem inputs
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } dcrs_modem_in_type;

endpackage

// [design/dcrs_input_isolation.sv]
module dcrs_input_isolation (
  // Isolation control
  input  wire logic                       isolate_i,
  // Raw inputs
  input  wire dcrs_pkg::dcrs_bus_req_type req_i,
  input  wire logic                       rx_serial_i,
  // Inputs as the logic sees them
  output      dcrs_pkg::dcrs_bus_req_type req_o,
  output      logic                       rx_serial_o
);

  // Isolated bus looks idle and the receive line idles high
  assign req_o       = isolate_i ? '0 : req_i;   // RL5
  assign rx_serial_o = isolate_i | rx_serial_i;  // RL5

endmodule

// [design/dcrs_channel.sv]
module dcrs_channel (
  // Clock and resets
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        por_i,
  // APB slave
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [7:0]                  paddr_i,
  input  wire logic [31:0]                 pwdata_i,
  output      logic [31:0]                 prdata_o,
  output      logic                        pready_o,
  output      logic                        pslverr_o,
  // Straps and sleep control
  input  wire logic                        bus_mode_68_i,
  input  wire logic                        input_isolation_sleep_i,
  // Serial and modem inputs
  input  wire logic                        rx_serial_i,
  input  wire dcrs_pkg::dcrs_modem_in_type modem_in_i,
  // Serializer side
  input  wire logic                        tx_load_i,
  input  wire logic                        rx_load_i,
  input  wire logic [7:0]                  rx_data_i,
  output      logic [7:0]                  tx_data_o,
  // Pins
  output      logic                        serial_tx_o,
  output      logic                        general_output_two_n_o,
  output      logic                        rts_n_o,
  output      logic                        dtr_n_o,
  output      logic                        receive_ready_pin_n_o,
  output      logic                        transmit_ready_pin_n_o,
  output      logic                        host_alert_o,
  output      logic                        host_alert_oe_o
);

  logic                       rst_any;
  logic                       isolate;
  logic                       rx_iso;
  dcrs_pkg::dcrs_bus_req_type req_raw;
  dcrs_pkg::dcrs_bus_req_type req;
  logic                       wr_acc;
  logic                       rd_acc;
  logic                       enh;
  logic [7:0]                 wd;
  logic [7:0]                 div_low_reg;
  logic [7:0]                 div_high_reg;
  logic [7:0]                 frac_div_reg;
  logic [7:0]                 irq_mask_reg;
  logic [7:0]                 fifo_ctl_reg;
  logic [7:0]                 line_fmt_reg;
  logic [7:0]                 modem_out_reg;
  logic [7:0]                 scratch_reg;
  logic [7:0]                 enh_feat_reg;
  logic [7:0]                 resume1_reg;
  logic [7:0]                 resume2_reg;
  logic [7:0]                 pause1_reg;
  logic [7:0]                 pause2_reg;
  logic [7:0]                 tx_hold_reg;
  logic [7:0]                 rx_hold_reg;
  logic                       tx_full_reg;
  logic                       rx_full_reg;
  logic [3:0]                 delta_reg;
  logic [3:0]                 status_prev_reg;
  logic [3:0]                 status_now;
  logic [3:0]                 delta_set;
  logic [7:0]                 line_stat;
  logic [7:0]                 irq_src;
  logic [7:0]                 modem_stat;
  logic                       irq_pending;
  logic                       sleep_reg;
  logic [7:0]                 rd_mux;
  logic                       mapped;
  logic [31:0]                prdata_reg;
  logic                       pslverr_reg;

  assign rst_any = sys_rst_i | por_i;

  // Bus request as a packed bundle; only the low byte of write data is used
  assign req_raw = '{sel: psel_i, enable: penable_i, write: pwrite_i, addr: paddr_i, wdata: pwdata_i[7:0]};

  // Sleep isolation stage on bus and receive line
  dcrs_input_isolation u_iso (
    .isolate_i   (isolate),
    .req_i       (req_raw),
    .rx_serial_i (rx_serial_i),
    .req_o       (req),
    .rx_serial_o (rx_iso)
  );

  assign isolate = input_isolation_sleep_i & sleep_reg;  // RL5
  assign wr_acc  = req.sel & req.enable & req.write;
  assign rd_acc  = req.sel & req.enable & ~req.write;
  assign wd      = req.wdata;
  assign enh     = enh_feat_reg[dcrs_pkg::BIT_ENH_ENABLE];

  // Divisor latches: only power-up restores them, the reset pin does not
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      div_low_reg  <= dcrs_pkg::RST_DIV_LOW;   // RL1
      div_high_reg <= dcrs_pkg::RST_DIV_HIGH;  // RL1
    end else begin
      if (wr_acc && req.addr == dcrs_pkg::ADDR_DIV_LOW) begin
        div_low_reg <= wd;
      end
      if (wr_acc && req.addr == dcrs_pkg::ADDR_DIV_HIGH) begin
        div_high_reg <= wd;
      end
    end
  end

  // Control registers; enhanced fields change only while enhanced enable is set
  always_ff @(posedge clk_i) begin
    if (rst_any) begin
      frac_div_reg  <= dcrs_pkg::RST_ZERO;  // RL2
      irq_mask_reg  <= dcrs_pkg::RST_ZERO;  // RL2
      fifo_ctl_reg  <= dcrs_pkg::RST_ZERO;  // RL2
      line_fmt_reg  <= dcrs_pkg::RST_ZERO;  // RL2
      modem_out_reg <= dcrs_pkg::RST_ZERO;  // RL2
      enh_feat_reg  <= dcrs_pkg::RST_ZERO;  // RL2
    end else if (wr_acc) begin
      unique case (req.addr)
        dcrs_pkg::ADDR_FRAC_DIV: begin
          if (enh) begin
            frac_div_reg <= wd;
          end
        end
        dcrs_pkg::ADDR_IRQ_MASK: begin
          irq_mask_reg <= enh ? wd : {irq_mask_reg[7:4], wd[3:0]};
        end
        dcrs_pkg::ADDR_FIFO_CTL: begin
          // Queue reset bits act once and are not stored
          fifo_ctl_reg <= {wd[7:6], enh ? wd[5:4] : fifo_ctl_reg[5:4], wd[3], 2'b00, wd[0]};
        end
        dcrs_pkg::ADDR_LINE_FMT: begin
          line_fmt_reg <= wd;
        end
        dcrs_pkg::ADDR_MODEM_OUT: begin
          modem_out_reg <= enh ? wd : {modem_out_reg[7:5], wd[4:0]};
        end
        dcrs_pkg::ADDR_ENH_FEAT: begin
          enh_feat_reg <= wd;
        end
        default: begin
        end
      endcase
    end
  end

  // Scratch and flow-control characters
  always_ff @(posedge clk_i) begin
    if (rst_any) begin
      scratch_reg <= dcrs_pkg::RST_SCRATCH;  // RL2
      resume1_reg <= dcrs_pkg::RST_ZERO;     // RL2
      resume2_reg <= dcrs_pkg::RST_ZERO;     // RL2
      pause1_reg  <= dcrs_pkg::RST_ZERO;     // RL2
      pause2_reg  <= dcrs_pkg::RST_ZERO;     // RL2
    end else if (wr_acc) begin
      unique case (req.addr)
        dcrs_pkg::ADDR_SCRATCH: begin
          scratch_reg <= wd;
        end
        dcrs_pkg::ADDR_RESUME1: begin
          resume1_reg <= wd;
        end
        dcrs_pkg::ADDR_RESUME2: begin
          resume2_reg <= wd;
        end
        dcrs_pkg::ADDR_PAUSE1: begin
          pause1_reg <= wd;
        end
        dcrs_pkg::ADDR_PAUSE2: begin
          pause2_reg <= wd;
        end
        default: begin
        end
      endcase
    end
  end

  // Transmit holding: a write fills it, the serializer or a queue reset empties it
  always_ff @(posedge clk_i) begin
    if (rst_any) begin
      tx_full_reg <= 1'b0;  // RL2
    end else if (wr_acc && req.addr == dcrs_pkg::ADDR_HOLDING) begin
      tx_full_reg <= 1'b1;
    end else if (tx_load_i || (wr_acc && req.addr == dcrs_pkg::ADDR_FIFO_CTL && wd[dcrs_pkg::BIT_TX_RESET])) begin
      tx_full_reg <= 1'b0;
    end
  end

  // Holding contents are left undefined by reset, so no reset term here
  always_ff @(posedge clk_i) begin
    if (wr_acc && req.addr == dcrs_pkg::ADDR_HOLDING) begin
      tx_hold_reg <= wd;
    end
    if (rx_load_i) begin
      rx_hold_reg <= rx_data_i;
    end
  end

  // Receive holding: a new byte wins over a read in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_any) begin
      rx_full_reg <= 1'b0;
    end else if (rx_load_i) begin
      rx_full_reg <= 1'b1;
    end else if ((rd_acc && req.addr == dcrs_pkg::ADDR_HOLDING)
                 || (wr_acc && req.addr == dcrs_pkg::ADDR_FIFO_CTL && wd[dcrs_pkg::BIT_RX_RESET])) begin
      rx_full_reg <= 1'b0;
    end
  end

  // Modem status: inverted pins, or modem outputs in loopback; never isolated
  always_comb begin
    if (modem_out_reg[dcrs_pkg::BIT_LOOPBACK]) begin
      status_now = {modem_out_reg[3], modem_out_reg[2], modem_out_reg[0], modem_out_reg[1]};
    end else begin
      status_now = ~{modem_in_i.cd_n, modem_in_i.ri_n, modem_in_i.dsr_n, modem_in_i.cts_n};  // RL3 RL5
    end
  end

  // Ring delta flags only the trailing edge of a ring
  assign delta_set = {status_now[3] ^ status_prev_reg[3],
                      ~status_now[2] & status_prev_reg[2],
                      status_now[1:0] ^ status_prev_reg[1:0]};

  // Previous level is loaded in reset so the release raises no false delta
  always_ff @(posedge clk_i) begin
    if (rst_any) begin
      status_prev_reg <= status_now;
      delta_reg       <= 4'h0;  // RL3
    end else begin
      status_prev_reg <= status_now;
      if (rd_acc && req.addr == dcrs_pkg::ADDR_MODEM_IN) begin
        delta_reg <= delta_set;  // Set wins over the clear of a read
      end else begin
        delta_reg <= delta_reg | delta_set;
      end
    end
  end

  // Upper half follows the pins with no register, so it is valid in reset too
  assign modem_stat = {status_now, delta_reg};  // RL3

  // Line status: empty flags high after reset
  assign line_stat = {1'b0, ~tx_full_reg, ~tx_full_reg, 4'h0, rx_full_reg};  // RL2

  // Interrupt source, highest priority first; 0x01 when nothing is pending
  always_comb begin
    if (irq_mask_reg[0] && rx_full_reg) begin
      irq_src = dcrs_pkg::SRC_RX_DATA;
    end else if (irq_mask_reg[1] && !tx_full_reg) begin
      irq_src = dcrs_pkg::SRC_TX_EMPTY;
    end else if (irq_mask_reg[3] && delta_reg != 4'h0) begin
      irq_src = dcrs_pkg::SRC_MODEM;
    end else begin
      irq_src = dcrs_pkg::RST_IRQ_SRC;  // RL2
    end
  end

  assign irq_pending = ~irq_src[0];

  // Sleep: entered when enabled and idle, left on any modem delta or activity
  always_ff @(posedge clk_i) begin
    if (rst_any) begin
      sleep_reg <= 1'b0;
    end else if (delta_set != 4'h0 || rx_load_i || irq_pending || delta_reg != 4'h0) begin
      sleep_reg <= 1'b0;  // RL5
    end else if (irq_mask_reg[dcrs_pkg::BIT_SLEEP_EN] && !rx_full_reg && !tx_full_reg) begin
      sleep_reg <= 1'b1;
    end
  end

  // Read decode
  always_comb begin
    mapped = 1'b1;
    unique case (req.addr)
      dcrs_pkg::ADDR_DIV_LOW:   rd_mux = div_low_reg;
      dcrs_pkg::ADDR_DIV_HIGH:  rd_mux = div_high_reg;
      dcrs_pkg::ADDR_FRAC_DIV:  rd_mux = frac_div_reg;
      dcrs_pkg::ADDR_IRQ_MASK:  rd_mux = irq_mask_reg;
      dcrs_pkg::ADDR_FIFO_CTL:  rd_mux = fifo_ctl_reg;
      dcrs_pkg::ADDR_IRQ_SRC:   rd_mux = irq_src;
      dcrs_pkg::ADDR_LINE_FMT:  rd_mux = line_fmt_reg;
      dcrs_pkg::ADDR_MODEM_OUT: rd_mux = modem_out_reg;
      dcrs_pkg::ADDR_LINE_STAT: rd_mux = line_stat;
      dcrs_pkg::ADDR_MODEM_IN:  rd_mux = modem_stat;
      dcrs_pkg::ADDR_SCRATCH:   rd_mux = scratch_reg;
      dcrs_pkg::ADDR_ENH_FEAT:  rd_mux = enh_feat_reg;
      dcrs_pkg::ADDR_RESUME1:   rd_mux = resume1_reg;
      dcrs_pkg::ADDR_RESUME2:   rd_mux = resume2_reg;
      dcrs_pkg::ADDR_PAUSE1:    rd_mux = pause1_reg;
      dcrs_pkg::ADDR_PAUSE2:    rd_mux = pause2_reg;
      dcrs_pkg::ADDR_HOLDING:   rd_mux = rx_hold_reg;
      dcrs_pkg::ADDR_CHAN_STAT: rd_mux = {5'h00, isolate, sleep_reg, rx_iso};
      default: begin
        rd_mux = 8'h00;
        mapped = 1'b0;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle so they leave flip-flops;
  // an isolated channel answers with an error and no effect
  always_ff @(posedge clk_i) begin
    if (rst_any) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel_i && !penable_i) begin
      prdata_reg  <= {24'h00_0000, rd_mux};
      pslverr_reg <= isolate | ~mapped;
    end
  end

  // Zero-wait access phase
  assign pready_o  = 1'b1;
  assign prdata_o  = prdata_reg;
  assign pslverr_o = pslverr_reg & psel_i & penable_i;
  assign tx_data_o = tx_hold_reg;

  // Pin levels; reset forces the documented idle levels at once
  assign serial_tx_o            = rst_any | ~line_fmt_reg[dcrs_pkg::BIT_BREAK];  // RL4
  assign general_output_two_n_o = rst_any | ~modem_out_reg[3];                   // RL4
  assign rts_n_o                = rst_any | ~modem_out_reg[1];                   // RL4
  assign dtr_n_o                = rst_any | ~modem_out_reg[0];                   // RL4
  assign receive_ready_pin_n_o  = rst_any | ~rx_full_reg;                        // RL4
  assign transmit_ready_pin_n_o = ~rst_any & tx_full_reg;                        // RL4

  // Alert: 16 mode drives high-active only when output two enables it, else floats;
  // 68 mode drives low-active always
  assign host_alert_oe_o = bus_mode_68_i | (~rst_any & modem_out_reg[3]);  // RL4
  assign host_alert_o    = bus_mode_68_i ? (rst_any | ~irq_pending) : (~rst_any & irq_pending);  // RL4

endmodule

// [sim/dcrs_channel_asserts.sv]
module dcrs_channel_asserts (
  // Clock and resets
  input wire logic                        clk_i,
  input wire logic                        sys_rst_i,
  input wire logic                        por_i,
  // Register bus
  input wire logic                        psel_i,
  input wire logic                        penable_i,
  input wire logic                        pwrite_i,
  input wire logic [7:0]                  paddr_i,
  input wire logic [31:0]                 pwdata_i,
  input wire logic [31:0]                 prdata_o,
  input wire logic                        pslverr_o,
  // Strap and modem inputs
  input wire logic                        bus_mode_68_i,
  input wire dcrs_pkg::dcrs_modem_in_type modem_in_i,
  // Pins
  input wire logic                        serial_tx_o,
  input wire logic                        general_output_two_n_o,
  input wire logic                        rts_n_o,
  input wire logic                        dtr_n_o,
  input wire logic                        receive_ready_pin_n_o,
  input wire logic                        transmit_ready_pin_n_o,
  input wire logic                        host_alert_o,
  input wire logic                        host_alert_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       acc_ok;
  logic [7:0] div_lo_reg;
  logic       scr_wr_reg;
  logic       loop_reg;
  // Accepted access: refused ones change nothing
  assign acc_ok = psel_i && penable_i && !pslverr_o;
  // Divisor shadow follows power-up and writes only, never the reset pin
  always_ff @(posedge clk_i) begin
    if (por_i) div_lo_reg <= dcrs_pkg::RST_DIV_LOW;
    else if (acc_ok && pwrite_i && paddr_i == dcrs_pkg::ADDR_DIV_LOW) div_lo_reg <= pwdata_i[7:0];
  end
  // Scratch written and loopback flags, both cleared by either reset
  always_ff @(posedge clk_i) begin
    if (por_i || sys_rst_i) begin
      scr_wr_reg <= 1'h0;
      loop_reg   <= 1'h0;
    end else if (acc_ok && pwrite_i) begin
      if (paddr_i == dcrs_pkg::ADDR_SCRATCH) scr_wr_reg <= 1'h1;
      if (paddr_i == dcrs_pkg::ADDR_MODEM_OUT) loop_reg <= pwdata_i[dcrs_pkg::BIT_LOOPBACK];
    end
  end
  // Reset pin forces idle pin levels; power-up is the disable since it also resets
  property p_rst_pins;
    @(posedge clk_i) disable iff (por_i)
      sys_rst_i |-> serial_tx_o && general_output_two_n_o && rts_n_o && dtr_n_o
        && receive_ready_pin_n_o && !transmit_ready_pin_n_o;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pin levels wrong during reset");
  property p_alert_68;
    @(posedge clk_i) disable iff (por_i) sys_rst_i && bus_mode_68_i |-> host_alert_oe_o && host_alert_o;
  endproperty
  a_alert_68: assert property (p_alert_68) else $error("alert not driven high in 68 mode reset");
  property p_alert_16;
    @(posedge clk_i) disable iff (por_i) sys_rst_i && !bus_mode_68_i |-> !host_alert_oe_o;
  endproperty
  a_alert_16: assert property (p_alert_16) else $error("alert not floating in 16 mode reset");
  property p_div_low;
    @(posedge clk_i) disable iff (por_i)
      acc_ok && !pwrite_i && paddr_i == dcrs_pkg::ADDR_DIV_LOW |-> prdata_o[7:0] == div_lo_reg;
  endproperty
  a_div_low: assert property (p_div_low) else $error("divisor low byte read wrong");
  property p_scratch;
    @(posedge clk_i) disable iff (por_i || sys_rst_i)
      acc_ok && !pwrite_i && paddr_i == dcrs_pkg::ADDR_SCRATCH && !scr_wr_reg |-> prdata_o[7:0] == 8'hff;
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch not at default after reset");
  property p_modem_msb;
    @(posedge clk_i) disable iff (por_i || sys_rst_i)
      acc_ok && !pwrite_i && paddr_i == dcrs_pkg::ADDR_MODEM_IN && !loop_reg && $stable(modem_in_i)
        |-> prdata_o[7:4] == ~modem_in_i;
  endproperty
  a_modem_msb: assert property (p_modem_msb) else $error("modem status upper nibble wrong");
  // Main scenarios reached
  c_refused: cover property (@(posedge clk_i) psel_i && penable_i && pslverr_o);
  c_pin_rst: cover property (@(posedge clk_i) $fell(sys_rst_i) && !por_i);
  c_mode_68: cover property (@(posedge clk_i) sys_rst_i && bus_mode_68_i);
endmodule

bind dcrs_channel dcrs_channel_asserts u_asserts (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .bus_mode_68_i(bus_mode_68_i), .modem_in_i(modem_in_i), .serial_tx_o(serial_tx_o),
  .general_output_two_n_o(general_output_two_n_o), .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o),
  .receive_ready_pin_n_o(receive_ready_pin_n_o), .transmit_ready_pin_n_o(transmit_ready_pin_n_o),
  .host_alert_o(host_alert_o), .host_alert_oe_o(host_alert_oe_o)
);

// [sim/dcrs_apb_host.sv]
module dcrs_apb_host (
  // Clock
  input  wire logic        clk_i,
  // Request
  output      logic        psel_o,
  output      logic        penable_o,
  output      logic        pwrite_o,
  output      logic [7:0]  paddr_o,
  output      logic [31:0] pwdata_o,
  // Answer
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic held;
  // Idle bus at time zero
  initial begin
    psel_o    = 1'h0;
    penable_o = 1'h0;
    pwrite_o  = 1'h0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0000_0000;
    held      = 1'h0;
  end
  // One transfer; hold keeps the bus so the next setup follows at once
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data, input logic hold,
                      output logic [7:0] rdata, output logic err);
    if (!held) @(posedge clk_i);
    psel_o    <= 1'h1;
    penable_o <= 1'h0;
    pwrite_o  <= wr;
    paddr_o   <= addr;
    pwdata_o  <= {24'h00_0000, data};
    @(posedge clk_i);
    penable_o <= 1'h1;
    // Only the bench watchdog ends this wait
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'h1);
    rdata = prdata_i[7:0];
    err   = pslverr_i;
    held  = hold;
    // Released lines must not keep looking valid
    if (!hold) begin
      psel_o    <= 1'h0;
      penable_o <= 1'h0;
      paddr_o   <= ~addr;
      pwdata_o  <= ~{24'h00_0000, data};
    end
  endtask
endmodule

// [sim/duart_channel_reset_state_tb.sv]
module duart_channel_reset_state_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] val;
  } dcrs_row_type;
  // Register and value expected after power-up
  localparam dcrs_row_type ROWS [15] = '{
    '{dcrs_pkg::ADDR_DIV_LOW, 8'h01}, '{dcrs_pkg::ADDR_DIV_HIGH, 8'h00}, '{dcrs_pkg::ADDR_FRAC_DIV, 8'h00},
    '{dcrs_pkg::ADDR_IRQ_MASK, 8'h00}, '{dcrs_pkg::ADDR_FIFO_CTL, 8'h00}, '{dcrs_pkg::ADDR_IRQ_SRC, 8'h01},
    '{dcrs_pkg::ADDR_LINE_FMT, 8'h00}, '{dcrs_pkg::ADDR_MODEM_OUT, 8'h00}, '{dcrs_pkg::ADDR_LINE_STAT, 8'h60},
    '{dcrs_pkg::ADDR_SCRATCH, 8'hff}, '{dcrs_pkg::ADDR_ENH_FEAT, 8'h00}, '{dcrs_pkg::ADDR_RESUME1, 8'h00},
    '{dcrs_pkg::ADDR_RESUME2, 8'h00}, '{dcrs_pkg::ADDR_PAUSE1, 8'h00}, '{dcrs_pkg::ADDR_PAUSE2, 8'h00}};
  // Bench signals
  logic clk, sys_rst, por, bus_mode_68, iso, rx_serial, tx_load, rx_load;
  logic psel, penable, pwrite, pready, pslverr;
  logic serial_tx, gen2_n, rts_n, dtr_n, rx_rdy_n, tx_rdy_n, alert, alert_oe;
  logic [7:0]  paddr, rx_data, tx_data, d;
  logic [31:0] pwdata, prdata;
  logic [7:0]  pins;
  logic        e;
  int          err_count, compares, n;
  dcrs_pkg::dcrs_modem_in_type modem_in;
  assign pins = {serial_tx, gen2_n, rts_n, dtr_n, rx_rdy_n, tx_rdy_n, alert_oe, alert};
  // Host and device
  dcrs_apb_host u_host (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
  dcrs_channel u_dut (.clk_i(clk), .sys_rst_i(sys_rst), .por_i(por), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .bus_mode_68_i(bus_mode_68), .input_isolation_sleep_i(iso), .rx_serial_i(rx_serial),
    .modem_in_i(modem_in), .tx_load_i(tx_load), .rx_load_i(rx_load), .rx_data_i(rx_data), .tx_data_o(tx_data),
    .serial_tx_o(serial_tx), .general_output_two_n_o(gen2_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
    .receive_ready_pin_n_o(rx_rdy_n), .transmit_ready_pin_n_o(tx_rdy_n), .host_alert_o(alert),
    .host_alert_oe_o(alert_oe));
  // 200 MHz clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'h0, a, 8'h00, 1'h0, d, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic hold);
    logic [7:0] unused;
    u_host.xfer(1'h1, a, v, hold, unused, e);
  endtask
  // Reset over four cycles, pin levels checked in both bus modes meanwhile
  task automatic do_reset(input logic pwr);
    @(posedge clk);
    sys_rst     <= 1'h1;
    por         <= pwr;
    bus_mode_68 <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("reset_pins_16", 9'h07c, {2'h0, pins[7:1]});
    @(posedge clk);
    bus_mode_68 <= 1'h1;
    modem_in    <= 4'hc;
    @(negedge clk);
    check("reset_pins_68", 9'h0fb, {1'h0, pins});
    @(posedge clk);
    sys_rst     <= 1'h0;
    por         <= 1'h0;
    bus_mode_68 <= 1'h0;
  endtask
  // Divisor rows keep the written value after a pin reset
  task automatic check_table(input logic keep);
    for (int i = 0; i < 15; i++) begin
      rd(ROWS[i].addr);
      check($sformatf("reg_%h", ROWS[i].addr), {1'h0, (keep && i < 2) ? 8'ha5 : ROWS[i].val}, {e, d});
    end
    rd(dcrs_pkg::ADDR_MODEM_IN);
    check("modem_status", 9'h030, {e, d});
  endtask
  // Time-zero values, then the tests in order
  initial begin
    sys_rst     = 1'h1;
    por         = 1'h1;
    bus_mode_68 = 1'h0;
    iso         = 1'h0;
    rx_serial   = 1'h0;
    modem_in    = 4'h5;
    tx_load     = 1'h0;
    rx_load     = 1'h0;
    rx_data     = 8'h00;
    err_count   = 0;
    compares    = 0;
    do_reset(1'h1);
    check_table(1'h0);
    $display("test power_up done");
    // Dirty every register and pin, writes back to back, read-only places too
    wr(dcrs_pkg::ADDR_ENH_FEAT, 8'h10, 1'h0);
    for (int i = 0; i < 15; i++) wr(ROWS[i].addr, 8'ha5, i < 14);
    wr(dcrs_pkg::ADDR_MODEM_OUT, 8'h0b, 1'h0);
    wr(dcrs_pkg::ADDR_LINE_FMT, 8'h40, 1'h0);
    wr(dcrs_pkg::ADDR_HOLDING, 8'h77, 1'h0);
    @(posedge clk);
    rx_load  <= 1'h1;
    rx_data  <= 8'h99;
    modem_in <= 4'h5;
    @(posedge clk);
    rx_load <= 1'h0;
    @(negedge clk);
    check("busy_pins", 9'h007, {1'h0, pins});
    check("tx_data_o", 9'h077, {1'h0, tx_data});
    do_reset(1'h0);
    check_table(1'h1);
    $display("test pin_reset done");
    // Sleep with isolation: bus ignored until a modem change wakes the channel
    wr(dcrs_pkg::ADDR_ENH_FEAT, 8'h10, 1'h0);
    wr(dcrs_pkg::ADDR_IRQ_MASK, 8'h10, 1'h0);
    n = 0;
    do begin
      rd(dcrs_pkg::ADDR_CHAN_STAT);
      n++;
    end while (d !== 8'h02 && n < 20);
    check("chan_status", 9'h002, {e, d});
    @(posedge clk);
    iso <= 1'h1;
    wr(dcrs_pkg::ADDR_SCRATCH, 8'h11, 1'h0);
    check("isolated_write", 9'h001, {8'h00, e});
    rd(dcrs_pkg::ADDR_SCRATCH);
    check("isolated_read", 9'h001, {8'h00, e});
    @(posedge clk);
    modem_in <= 4'hd;
    n = 0;
    do begin
      rd(dcrs_pkg::ADDR_SCRATCH);
      n++;
    end while (e !== 1'h0 && n < 20);
    check("scratch_after_wake", 9'h0ff, {e, d});
    @(posedge clk);
    iso <= 1'h0;
    rd(8'h48);
    check("unmapped_read", 9'h100, {e, d});
    // Loopback: status follows modem outputs, the clear-to-send change adds no new delta bit
    wr(dcrs_pkg::ADDR_MODEM_OUT, 8'h13, 1'h0);
    rd(dcrs_pkg::ADDR_MODEM_IN);
    check("loopback_status", 9'h031, {e, d});
    $display("test isolation done");
    print_verdict();
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule
